// ==== rtl/tkr_pkg.sv ====
// shared constants and carrier types for the touch key reference tracker
// assumes one key sample at a time from the scan sequencer, all on clk
package tkr_pkg;

  // widths of the per-key datapath
  localparam int KEY_W    = 6;
  localparam int MAX_KEYS = 64;
  localparam int SIG_W    = 8;
  localparam int DI_W     = 4;
  localparam int RATE_W   = 8;
  localparam int DLY_W    = 8;
  localparam int OFS_W    = 8;
  localparam int NCZ_W    = 2;
  localparam int COEF1_W  = 16;
  localparam int COEF2_W  = 8;
  localparam int GNEG_W   = 7;
  localparam int GPOS_W   = 7;
  localparam int ABS_W    = 20;
  localparam int ERR_W    = 4;
  localparam int ERR_HI_BIT = 2;
  localparam int ERR_LO_BIT = 3;

  // rails of the 8-bit signal window
  localparam logic [SIG_W-1:0] REF_TOP    = 8'hff;
  localparam logic [SIG_W-1:0] REF_BOTTOM = 8'h00;

  // hysteresis selection and the matching right shift of the threshold
  localparam logic [1:0] HYST_12P5  = 2'h0;
  localparam logic [1:0] HYST_25    = 2'h1;
  localparam logic [1:0] HYST_50    = 2'h2;
  localparam logic [2:0] SHIFT_12P5 = 3'h3;
  localparam logic [2:0] SHIFT_25   = 3'h2;
  localparam logic [2:0] SHIFT_50   = 3'h1;

  // guardband scaling: percent base, positive step and setting ceilings
  localparam logic [GNEG_W-1:0] PCT_FULL     = 7'h64;
  localparam logic [3:0]        POS_PCT_STEP = 4'ha;
  localparam logic [GNEG_W-1:0] GNEG_MAX     = 7'h63;
  localparam logic [GPOS_W-1:0] GPOS_MAX     = 7'h64;

  typedef struct packed {
    logic             valid;
    logic [KEY_W-1:0] key;
    logic [SIG_W-1:0] signal;
  } tkr_sample_t;

  typedef struct packed {
    logic [SIG_W-1:0]  neg_thr;
    logic [SIG_W-1:0]  pos_thr;
    logic [RATE_W-1:0] drift_up;
    logic [RATE_W-1:0] drift_dn;
    logic              drift_en;
    logic [DLY_W-1:0]  neg_dly;
    logic [DLY_W-1:0]  pos_dly;
    logic [DI_W-1:0]   di_limit;
  } tkr_key_cfg_t;

  localparam tkr_key_cfg_t CFG_DEFAULT = '{
    neg_thr: 8'h14, pos_thr: 8'h0a, drift_up: 8'h04, drift_dn: 8'h10,
    drift_en: 1'b1, neg_dly: 8'hff, pos_dly: 8'h08, di_limit: 4'h3};

  typedef struct packed {
    logic [1:0]         neg_hyst;
    logic [COEF1_W-1:0] coarse_coefficient;
    logic [COEF2_W-1:0] offset_coefficient;
    logic [GNEG_W-1:0]  guard_neg;
    logic [GPOS_W-1:0]  guard_pos;
  } tkr_glob_t;

  typedef struct packed {
    logic             valid;
    logic [KEY_W-1:0] key;
    logic [OFS_W-1:0] offset;
    logic [NCZ_W-1:0] coarse_cap_count;
    logic [SIG_W-1:0] signal;
  } tkr_cal_t;

  typedef struct packed {
    logic             valid;
    logic             all;
    logic [KEY_W-1:0] key;
  } tkr_cal_req_t;

  typedef struct packed {
    logic             valid;
    logic [KEY_W-1:0] key;
    logic [SIG_W-1:0] reference;
    logic [DI_W-1:0]  detect_integrator_count;
    logic             detect;
    logic [ERR_W-1:0] error;
    logic             fast_recal;
  } tkr_report_t;

endpackage

// ==== rtl/tkr_guard.sv ====
// absolute reference and guardband comparison for one key, combinational
// assumes the caller registers the flags and decides when they count
module tkr_guard (
  // global coefficients and limits
  input  wire logic [tkr_pkg::COEF1_W-1:0] coarse_coefficient,
  input  wire logic [tkr_pkg::COEF2_W-1:0] offset_coefficient,
  input  wire logic [tkr_pkg::GNEG_W-1:0]  guard_neg,
  input  wire logic [tkr_pkg::GPOS_W-1:0]  guard_pos,
  // per-key values
  input  wire logic [tkr_pkg::NCZ_W-1:0]   coarse_cap_count,
  input  wire logic [tkr_pkg::OFS_W-1:0]   offset,
  input  wire logic [tkr_pkg::SIG_W-1:0]   window_reference,
  input  wire logic [tkr_pkg::ABS_W-1:0]   locked_reference,
  // results
  output logic      [tkr_pkg::ABS_W-1:0]   absolute_reference,
  output logic                             over,
  output logic                             under
);
  logic [tkr_pkg::GNEG_W-1:0] neg_eff;
  logic [tkr_pkg::GPOS_W-1:0] pos_eff;
  logic [31:0]                scaled;

  // out-of-range settings clamp to the ceiling rather than wrap
  always_comb begin
    absolute_reference = tkr_pkg::ABS_W'(coarse_coefficient * coarse_cap_count)
                       + tkr_pkg::ABS_W'(offset_coefficient * offset)
                       + tkr_pkg::ABS_W'(window_reference);
    neg_eff = (guard_neg > tkr_pkg::GNEG_MAX) ? tkr_pkg::GNEG_MAX : guard_neg;
    pos_eff = (guard_pos > tkr_pkg::GPOS_MAX) ? tkr_pkg::GPOS_MAX : guard_pos;
    scaled  = 32'(absolute_reference) * 32'(tkr_pkg::PCT_FULL);
    // percent tests by cross-multiplying, no divider needed
    under = (neg_eff != '0) && (scaled < 32'(locked_reference)
          * 32'(tkr_pkg::PCT_FULL - neg_eff));
    over  = (pos_eff != '0) && (scaled > 32'(locked_reference)
          * (32'(tkr_pkg::PCT_FULL) + 32'(pos_eff) * 32'(tkr_pkg::POS_PCT_STEP)));
  end
endmodule

// ==== rtl/tkr_tracker.sv ====
// per-key reference tracking, detect integration and guardbanding
// assumes one burst result per cycle at most, keyed by index, from the scanner
module tkr_tracker #(
  parameter int NUM_KEYS = 64
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // burst results from the scanner
  input  wire tkr_pkg::tkr_sample_t  sample,
  // per-key setup writes
  input  wire logic                  cfg_we,
  input  wire logic [tkr_pkg::KEY_W-1:0] cfg_key,
  input  wire tkr_pkg::tkr_key_cfg_t cfg_data,
  // global setup
  input  wire tkr_pkg::tkr_glob_t    glob,
  // full calibration results from the front end
  input  wire tkr_pkg::tkr_cal_t     cal_res,
  // host commands, one-cycle pulses
  input  wire logic                  recal_cmd,
  input  wire logic                  recal_all,
  input  wire logic [tkr_pkg::KEY_W-1:0] recal_key,
  input  wire logic                  lock_cmd,
  input  wire logic                  nv_erase,
  // outputs
  output tkr_pkg::tkr_cal_req_t      cal_req,
  output tkr_pkg::tkr_report_t       report,
  output logic [NUM_KEYS-1:0]        detect_vec,
  output logic [NUM_KEYS-1:0]        error_vec,
  output logic                       lock_busy
);
  // key count must fit the 6-bit key index
  if (NUM_KEYS < 1 || NUM_KEYS > tkr_pkg::MAX_KEYS) begin : g_bad_keys
    $error("NUM_KEYS out of range");
  end

  // cause of the last update, kept so the checks can relate it to the result
  typedef struct packed {
    logic                      valid;
    logic                      below;
    logic                      between;
    logic                      fast;
    logic                      det_before;
    logic [tkr_pkg::DI_W-1:0]  di_before;
    logic [tkr_pkg::DI_W-1:0]  limit;
    logic [tkr_pkg::SIG_W-1:0] ref_before;
    logic [tkr_pkg::SIG_W-1:0] sig;
  } tkr_cause_t;

  typedef struct packed {
    logic                  boot;
    tkr_pkg::tkr_cal_req_t cal_req;
    tkr_pkg::tkr_report_t  rep;
    tkr_cause_t            cause;
    logic [NUM_KEYS-1:0]   det_vec;
    logic [NUM_KEYS-1:0]   err_vec;
    logic [NUM_KEYS-1:0]   lock_pend;
    logic                  lock_busy;
  } tkr_state_t;

  tkr_state_t s_r;
  tkr_state_t s_nxt;

  // per-key memories; lock storage stands in for nonvolatile cells
  tkr_pkg::tkr_key_cfg_t             cfg_mem   [NUM_KEYS];
  logic [tkr_pkg::SIG_W-1:0]         ref_mem   [NUM_KEYS];
  logic [tkr_pkg::DI_W-1:0]          di_mem    [NUM_KEYS];
  logic [tkr_pkg::RATE_W-1:0]        drift_mem [NUM_KEYS];
  logic [tkr_pkg::DLY_W-1:0]         negt_mem  [NUM_KEYS];
  logic [tkr_pkg::DLY_W-1:0]         post_mem  [NUM_KEYS];
  logic [tkr_pkg::OFS_W-1:0]         ofs_mem   [NUM_KEYS];
  logic [tkr_pkg::NCZ_W-1:0]         ncz_mem   [NUM_KEYS];
  logic [tkr_pkg::ERR_W-1:0]         err_mem   [NUM_KEYS];
  logic [NUM_KEYS-1:0]               arm_vec;
  logic [tkr_pkg::ABS_W-1:0]         lock_abs  [NUM_KEYS];
  logic [NUM_KEYS-1:0]               lock_vld;

  // combinational next values for the key being processed
  logic                       upd;
  logic [tkr_pkg::KEY_W-1:0]  k;
  tkr_pkg::tkr_key_cfg_t      c;
  logic [tkr_pkg::SIG_W-1:0]  sig;
  logic [tkr_pkg::SIG_W-1:0]  cur_ref;
  logic [tkr_pkg::SIG_W-1:0]  n_ref;
  logic [tkr_pkg::DI_W-1:0]   n_di;
  logic                       n_det;
  logic [tkr_pkg::RATE_W-1:0] n_cnt;
  logic [tkr_pkg::DLY_W-1:0]  n_negt;
  logic [tkr_pkg::DLY_W-1:0]  n_post;
  logic [tkr_pkg::ERR_W-1:0]  n_err;
  logic                       n_fast;
  logic [tkr_pkg::SIG_W-1:0]  hyst_mag;
  logic [2:0]                 hyst_sh;
  logic                       below;
  logic                       between;
  logic                       pos_exc;
  logic                       drift_ok;
  logic [tkr_pkg::ABS_W-1:0]  abs_ref;
  logic                       g_over;
  logic                       g_under;

  tkr_guard u_guard (
    .coarse_coefficient (glob.coarse_coefficient),
    .offset_coefficient (glob.offset_coefficient),
    .guard_neg          (glob.guard_neg),
    .guard_pos          (glob.guard_pos),
    .coarse_cap_count   (ncz_mem[k]),
    .offset             (ofs_mem[k]),
    .window_reference   (n_ref),
    .locked_reference   (lock_abs[k]),
    .absolute_reference (abs_ref),
    .over               (g_over),
    .under              (g_under)
  );

  // classify the sample and step drift, integrator and both timers
  always_comb begin
    s_nxt = s_r;
    s_nxt.boot = 1'b0;
    s_nxt.cal_req = '0;
    s_nxt.rep.valid = 1'b0;
    s_nxt.cause.valid = 1'b0;
    // calibration results win; a sample in the same cycle is dropped
    upd = sample.valid && !cal_res.valid;
    k = sample.key;
    c = cfg_mem[k];
    sig = sample.signal;
    cur_ref = ref_mem[k];
    case (glob.neg_hyst)
      tkr_pkg::HYST_12P5: hyst_sh = tkr_pkg::SHIFT_12P5;
      tkr_pkg::HYST_25:   hyst_sh = tkr_pkg::SHIFT_25;
      tkr_pkg::HYST_50:   hyst_sh = tkr_pkg::SHIFT_50;
      default:            hyst_sh = tkr_pkg::SHIFT_25;
    endcase
    // hysteresis point sits between threshold and reference, tracking both
    hyst_mag = c.neg_thr - (c.neg_thr >> hyst_sh);
    below = (sig < cur_ref) && ((cur_ref - sig) >= c.neg_thr);
    between = (sig < cur_ref) && ((cur_ref - sig) > hyst_mag) && !below;
    pos_exc = (sig > cur_ref) && ((sig - cur_ref) > c.pos_thr);
    n_ref = cur_ref;
    n_di = di_mem[k];
    n_det = s_r.det_vec[k];
    n_cnt = drift_mem[k];
    n_negt = negt_mem[k];
    n_post = post_mem[k];
    n_err = err_mem[k];
    n_fast = 1'b0;
    // drift only with no detection, below-threshold or saturation pending
    drift_ok = c.drift_en && !n_det && !below
             && !n_err[tkr_pkg::ERR_HI_BIT] && !n_err[tkr_pkg::ERR_LO_BIT];
    if (drift_ok && sig > cur_ref) begin
      if (cur_ref == tkr_pkg::REF_TOP) begin
        n_err[tkr_pkg::ERR_HI_BIT] = 1'b1;
      end else if (n_cnt + 8'h01 >= c.drift_up) begin
        n_ref = cur_ref + 8'h01;
        n_err[tkr_pkg::ERR_HI_BIT] = (n_ref == tkr_pkg::REF_TOP); // no sample passes a rail
        n_cnt = '0;
      end else begin
        n_cnt = n_cnt + 8'h01;
      end
    end else if (drift_ok && sig < cur_ref) begin
      if (cur_ref == tkr_pkg::REF_BOTTOM) begin
        n_err[tkr_pkg::ERR_LO_BIT] = 1'b1;
      end else if (n_cnt + 8'h01 >= c.drift_dn) begin
        n_ref = cur_ref - 8'h01;
        n_err[tkr_pkg::ERR_LO_BIT] = (n_ref == tkr_pkg::REF_BOTTOM);
        n_cnt = '0;
      end else begin
        n_cnt = n_cnt + 8'h01;
      end
    end else begin
      n_cnt = '0;
    end
    // detect integrator
    if (c.di_limit == '0) begin
      n_di = '0;
      n_det = 1'b0;
    end else if (!n_det) begin
      if (below) begin
        if (n_di + 4'h1 >= c.di_limit) begin
          n_di = c.di_limit;
          n_det = 1'b1;
        end else begin
          n_di = n_di + 4'h1;
        end
      end else if (between) begin
        n_di = (n_di == '0) ? '0 : n_di - 4'h1;
      end else begin
        n_di = '0;
      end
    end else if (below) begin
      n_di = c.di_limit;
    end else if (n_di <= 4'h1) begin
      n_di = '0;
      n_det = 1'b0;
    end else begin
      n_di = n_di - 4'h1;
    end
    // negative recal timer runs for the whole detection
    if (s_r.det_vec[k] && c.neg_dly != '0) begin
      if (n_negt + 8'h01 >= c.neg_dly) begin
        n_fast = 1'b1;
      end else begin
        n_negt = n_negt + 8'h01;
      end
    end else begin
      n_negt = '0;
    end
    // positive excursion timer
    if (pos_exc && c.pos_dly != '0) begin
      if (n_post + 8'h01 >= c.pos_dly) begin
        n_fast = 1'b1;
      end else begin
        n_post = n_post + 8'h01;
      end
    end else begin
      n_post = '0;
    end
    // fast recal reloads the reference and clears integrator, detect, both timers and drift count, never offset or coarse caps
    if (n_fast) begin
      n_ref = sig;
      n_di = '0;
      n_det = 1'b0;
      n_negt = '0;
      n_post = '0;
      n_cnt = '0;
    end
    // guardband errors are only flagged; recovery stays with the host
    if (arm_vec[k] || (n_fast && lock_vld[k])) begin
      n_err[tkr_pkg::ERR_HI_BIT] = n_err[tkr_pkg::ERR_HI_BIT] | g_over;
      n_err[tkr_pkg::ERR_LO_BIT] = n_err[tkr_pkg::ERR_LO_BIT] | g_under;
    end
    if (upd) begin
      s_nxt.det_vec[k] = n_det;
      s_nxt.err_vec[k] = |n_err;
      s_nxt.lock_pend[k] = 1'b0;
      s_nxt.rep = '{valid: 1'b1, key: k, reference: n_ref,
                    detect_integrator_count: n_di, detect: n_det,
                    error: n_err, fast_recal: n_fast};
      s_nxt.cause = '{valid: 1'b1, below: below, between: between, fast: n_fast,
                      det_before: s_r.det_vec[k], di_before: di_mem[k],
                      limit: c.di_limit, ref_before: cur_ref, sig: sig};
    end
    // full calibration restarts the key from scratch
    if (cal_res.valid) begin
      s_nxt.det_vec[cal_res.key] = 1'b0;
      s_nxt.err_vec[cal_res.key] = 1'b0;
    end
    if (lock_cmd) begin
      s_nxt.lock_pend = '1;
    end
    s_nxt.lock_busy = |s_nxt.lock_pend; // registered so the output is a flop
    // reset release and host command both request full calibration
    if (s_r.boot || recal_cmd) begin
      s_nxt.cal_req = '{valid: 1'b1, all: s_r.boot || recal_all, key: recal_key};
    end
  end

  // state register and per-key memories
  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
      s_r.boot <= 1'b1;
      arm_vec <= '0;
      for (int i = 0; i < NUM_KEYS; i++) begin
        cfg_mem[i] <= tkr_pkg::CFG_DEFAULT;
        ref_mem[i] <= '0;
        di_mem[i] <= '0;
        drift_mem[i] <= '0;
        negt_mem[i] <= '0;
        post_mem[i] <= '0;
        ofs_mem[i] <= '0;
        ncz_mem[i] <= '0;
        err_mem[i] <= '0;
      end
    end else begin
      s_r <= s_nxt;
      if (cfg_we) begin
        cfg_mem[cfg_key] <= cfg_data;
      end
      if (cal_res.valid) begin
        ref_mem[cal_res.key] <= cal_res.signal;
        ofs_mem[cal_res.key] <= cal_res.offset;
        ncz_mem[cal_res.key] <= cal_res.coarse_cap_count;
        di_mem[cal_res.key] <= '0;
        drift_mem[cal_res.key] <= '0;
        negt_mem[cal_res.key] <= '0;
        post_mem[cal_res.key] <= '0;
        err_mem[cal_res.key] <= '0;
        arm_vec[cal_res.key] <= lock_vld[cal_res.key];
      end else if (upd) begin
        ref_mem[k] <= n_ref;
        di_mem[k] <= n_di;
        drift_mem[k] <= n_cnt;
        negt_mem[k] <= n_negt;
        post_mem[k] <= n_post;
        err_mem[k] <= n_err;
        if (n_fast && lock_vld[k]) begin
          arm_vec[k] <= 1'b1;
        end
      end
    end
  end

  // lock storage survives reset; only an explicit erase clears it
  always_ff @(posedge clk) begin
    if (nv_erase) begin
      lock_vld <= '0;
    end else if (upd && s_r.lock_pend[k]) begin
      lock_abs[k] <= abs_ref;
      lock_vld[k] <= 1'b1;
    end
  end

  assign cal_req    = s_r.cal_req;
  assign report     = s_r.rep;
  assign detect_vec = s_r.det_vec;
  assign error_vec  = s_r.err_vec;
  assign lock_busy  = s_r.lock_busy;

  // checks on the registered report against the registered cause, and on recal_cmd forwarding to cal_req
  property p_detect_at_limit;
    @(posedge clk) disable iff (reset)
    s_r.rep.valid && s_r.rep.detect && !s_r.cause.det_before
      |-> s_r.rep.detect_integrator_count == s_r.cause.limit && s_r.cause.below;
  endproperty
  a_detect_at_limit: assert property (p_detect_at_limit) else $error("detect without limit");

  property p_between_dec;
    @(posedge clk) disable iff (reset)
    s_r.cause.valid && !s_r.cause.det_before && s_r.cause.between && !s_r.cause.fast
      && s_r.cause.limit != '0
      |-> s_r.rep.detect_integrator_count == ((s_r.cause.di_before == '0) ? '0
          : s_r.cause.di_before - 4'h1);
  endproperty
  a_between_dec: assert property (p_between_dec) else $error("integrator not decremented");

  property p_above_clear;
    @(posedge clk) disable iff (reset)
    s_r.cause.valid && !s_r.cause.det_before && !s_r.cause.below && !s_r.cause.between
      |-> s_r.rep.detect_integrator_count == '0 && !s_r.rep.detect;
  endproperty
  a_above_clear: assert property (p_above_clear) else $error("integrator not cleared");

  property p_limit_zero;
    @(posedge clk) disable iff (reset)
    s_r.cause.valid && s_r.cause.limit == '0 |-> !s_r.rep.detect;
  endproperty
  a_limit_zero: assert property (p_limit_zero) else $error("detect with zero limit");

  property p_no_drift_below;
    @(posedge clk) disable iff (reset)
    s_r.cause.valid && (s_r.cause.below || s_r.cause.det_before) && !s_r.cause.fast
      |-> s_r.rep.reference == s_r.cause.ref_before;
  endproperty
  a_no_drift_below: assert property (p_no_drift_below) else $error("drift during detection");

  property p_slew;
    @(posedge clk) disable iff (reset)
    s_r.cause.valid && !s_r.cause.fast
      |-> s_r.rep.reference == s_r.cause.ref_before
       || s_r.rep.reference == s_r.cause.ref_before + 8'h01
       || s_r.rep.reference == s_r.cause.ref_before - 8'h01;
  endproperty
  a_slew: assert property (p_slew) else $error("reference step too large");

  property p_fast_copy;
    @(posedge clk) disable iff (reset)
    s_r.cause.valid && s_r.cause.fast
      |-> s_r.rep.reference == s_r.cause.sig && !s_r.rep.detect;
  endproperty
  a_fast_copy: assert property (p_fast_copy) else $error("fast recal did not copy");

  property p_release;
    @(posedge clk) disable iff (reset)
    s_r.cause.valid && s_r.cause.det_before && !s_r.cause.below && !s_r.cause.fast
      && s_r.cause.di_before > 4'h1 && s_r.cause.limit != '0 |-> s_r.rep.detect;
  endproperty
  a_release: assert property (p_release) else $error("detect dropped early");

  property p_cmd_req;
    @(posedge clk) disable iff (reset)
    recal_cmd |=> cal_req.valid ##1 !cal_req.valid || $past(recal_cmd);
  endproperty
  a_cmd_req: assert property (p_cmd_req) else $error("recal command not forwarded");

  c_detect: cover property (@(posedge clk) disable iff (reset)
    s_r.rep.valid && s_r.rep.detect && !s_r.cause.det_before);
  c_fast: cover property (@(posedge clk) disable iff (reset) s_r.rep.fast_recal);
  c_error: cover property (@(posedge clk) disable iff (reset) |s_r.err_vec);
  c_rel: cover property (@(posedge clk) disable iff (reset)
    s_r.cause.valid && s_r.cause.det_before && !s_r.rep.detect);
endmodule

// ==== verification/tkr_host.sv ====
// host controller model: per-key setup writes and one-cycle commands
// assumes each task is entered just after a rising edge of clk
module tkr_host (
  // clock
  input  wire logic                      clk,
  // setup and commands toward the tracker
  output tkr_pkg::tkr_key_cfg_t          cfg_data,
  output logic                           cfg_we,
  output logic [tkr_pkg::KEY_W-1:0]      cfg_key,
  output logic                           recal_cmd,
  output logic                           recal_all,
  output logic [tkr_pkg::KEY_W-1:0]      recal_key,
  output logic                           lock_cmd,
  output logic                           nv_erase
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle levels from time zero
  initial begin
    {cfg_we, recal_cmd, recal_all, lock_cmd, nv_erase} = '0;
    {cfg_key, recal_key} = '0;
    cfg_data = tkr_pkg::CFG_DEFAULT;
  end

  // callers keep drift_up below drift_dn, so rising signals track faster
  task automatic wr(input logic [5:0] k, input tkr_pkg::tkr_key_cfg_t c);
    cfg_key = k;
    cfg_data = c;
    cfg_we = 1'b1;
    @(posedge clk);
    #1 cfg_we = 1'b0;
    @(posedge clk);
    #1;
  endtask

  // full recal, as a host does after reading a raised error flag
  // returns one step after the taking edge so the caller sees cal_req
  task automatic recal(input logic [5:0] k, input logic a);
    recal_key = k;
    recal_all = a;
    recal_cmd = 1'b1;
    @(posedge clk);
    #1 recal_cmd = 1'b0;
  endtask

  // lock command; every key records at its next processed sample
  task automatic lock();
    lock_cmd = 1'b1;
    @(posedge clk);
    #1 lock_cmd = 1'b0;
  endtask

  // lock storage is undefined until erased once
  task automatic erase();
    nv_erase = 1'b1;
    @(posedge clk);
    #1 nv_erase = 1'b0;
    @(posedge clk);
    #1;
  endtask
endmodule

// ==== verification/tb.sv ====
// self-checking bench for the reference tracker with a host model beside it
// assumes each taken sample is reported exactly one cycle later
`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); \
  end \
end

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                      clk, reset, cfg_we, recal_cmd, recal_all, lock_cmd, nv_erase;
  logic                      lock_busy;
  logic [tkr_pkg::KEY_W-1:0] cfg_key, recal_key, kb;
  tkr_pkg::tkr_sample_t      sample;
  tkr_pkg::tkr_key_cfg_t     cfg_data, c;
  tkr_pkg::tkr_glob_t        glob;
  tkr_pkg::tkr_cal_t         cal_res;
  tkr_pkg::tkr_cal_req_t     cal_req;
  tkr_pkg::tkr_report_t      report;
  logic [63:0]               detect_vec, error_vec;
  logic [23:0]               q[$];
  logic [23:0]               exp_v;
  int                        mismatches, tests_run;
  // key offset, signal, expected reference, integrator, {err3, err2, detect, fast recal}
  logic [27:0] tbl [28] = '{
    28'h0608010, 28'h0608020, 28'h0608032, 28'h0608032, 28'h0808022,
    28'h0808012, 28'h0808000, 28'h0608010, 28'h0608020, 28'h06d8010,
    28'h06d8000, 28'h06d8000, 28'h0608010, 28'h0608020, 28'h0808000,
    28'h1608010, 28'h1608020, 28'h1608032, 28'h1608032, 28'h1606001,
    28'h1606000, 28'h1806000, 28'h1808001,
    28'h2828100, 28'h2828200, 28'h2828200, 28'h2608210, 28'h2828200};

  tkr_tracker #(.NUM_KEYS(64)) tkr_tracker_i (.clk(clk), .reset(reset), .sample(sample),
    .cfg_we(cfg_we), .cfg_key(cfg_key), .cfg_data(cfg_data), .glob(glob), .cal_res(cal_res),
    .recal_cmd(recal_cmd), .recal_all(recal_all), .recal_key(recal_key), .lock_cmd(lock_cmd),
    .nv_erase(nv_erase), .cal_req(cal_req), .report(report), .detect_vec(detect_vec),
    .error_vec(error_vec), .lock_busy(lock_busy));
  tkr_host tkr_host_i (.clk(clk), .cfg_data(cfg_data), .cfg_we(cfg_we), .cfg_key(cfg_key),
    .recal_cmd(recal_cmd), .recal_all(recal_all), .recal_key(recal_key),
    .lock_cmd(lock_cmd), .nv_erase(nv_erase));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // one burst result; the expected report is queued before driving
  task automatic smp(input logic [27:0] t);
    logic [5:0] k;
    k = kb + 6'(t[27:24]);
    q.push_back({k, t[15:4], t[1:0], t[3:2], 2'h0});
    sample = '{valid: 1'b1, key: k, signal: t[23:16]};
    tick();
    sample.valid = 1'b0;
    tick();
  endtask

  // full calibration result; offset and coarse caps only matter to guarding
  task automatic cal(input logic [5:0] k, input logic [7:0] s);
    cal_res = '{valid: 1'b1, key: k, offset: 8'($urandom), coarse_cap_count: 2'($urandom),
                signal: s};
    tick();
    cal_res.valid = 1'b0;
    tick();
  endtask

  task automatic results();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // reports sampled mid-cycle, after the register update has settled
  always @(negedge clk) begin
    if (report.valid === 1'b1) begin
      exp_v = (q.size() == 0) ? 24'h0 : q.pop_front();
      `CHK({report.key, report.reference, report.detect_integrator_count, report.detect, report.fast_recal, report.error}, exp_v)
      `CHK({detect_vec[report.key], error_vec[report.key]}, {exp_v[5], |exp_v[3:0]})
    end
  end

  initial begin
    reset = 1'b1;
    sample = '0;
    cal_res = '0;
    glob = '{tkr_pkg::HYST_12P5, 16'h0010, 8'h02, 7'h00, 7'h00};
    void'($urandom(4189));
    kb = 6'(8 + $urandom % 40);
    repeat (16) @(posedge clk);
    #1 reset = 1'b0;
    tick();
    `CHK({cal_req.valid, cal_req.all}, 2'b11)
    tkr_host_i.erase();
    // key a: plain detect, key b: both fast recals, key c: drift only
    c = '{8'h14, 8'h0a, 8'h01, 8'h02, 1'b0, 8'h00, 8'h00, 4'h3};
    tkr_host_i.wr(kb, c);
    c.neg_dly = 8'h02;
    c.pos_dly = 8'h02;
    tkr_host_i.wr(kb + 6'd1, c);
    c.neg_dly = 8'h00;
    c.pos_dly = 8'h00;
    c.drift_en = 1'b1;
    tkr_host_i.wr(kb + 6'd2, c);
    for (int i = 0; i < 3; i++) cal(kb + 6'(i), 8'h80);
    foreach (tbl[i]) smp(tbl[i]);
    // rails: drift onto 0xff or 0x00 raises a sticky flag and stops drift
    cal(kb + 6'd2, 8'hfe);
    smp(28'h2ffff04);
    smp(28'h2f0ff04);
    `CHK(error_vec[kb + 6'd2], 1'b1)
    cal(kb + 6'd2, 8'h01);
    `CHK(error_vec[kb + 6'd2], 1'b0)
    smp(28'h2000100);
    smp(28'h2000008);
    // zero coefficients make absolute equal window reference; key b falls under 50%
    glob = '{tkr_pkg::HYST_12P5, 16'h0000, 8'h00, 7'h32, 7'h01};
    tkr_host_i.lock();
    `CHK(lock_busy, 1'b1)
    smp(28'h1808000);
    smp(28'h1308010);
    smp(28'h1308020);
    smp(28'h1308032);
    smp(28'h1308032);
    smp(28'h1303009);
    smp(28'h1303008);
    // host recal command, single key then all keys
    for (int a = 0; a < 2; a++) begin
      tkr_host_i.recal(kb + 6'd3, a[0]);
      `CHK({cal_req.valid, cal_req.all, cal_req.key}, {1'b1, a[0], kb + 6'd3})
      tick();
    end
    for (int n = 0; n < 20 && q.size() != 0; n++) tick();
    `CHK(q.size(), 0)
    results();
  end
endmodule
